// >>> core/vp_top.sv
// voltage protection element with axi4-lite register slave
// How it works
// - one structure, over or under mode
// - phase-ground: flags follow phase voltages
// - phase-phase: flags follow line voltages
// - compare fundamental or true rms value
// - sliding average option, ten minute window
// - nominal is rating over root three or rating
// - phase-phase connection forces phase-phase nominal
// - minimum current only in undervoltage mode
// - minimum current acts only when enabled
// - all currents below threshold block element
// - re-enable after delay once current returns
// - currents come from neutral side inputs
// - pickup below three percent in under mode sets a status flag
// - external block inhibits when activation set
// - pickup on one, two or three phases
`timescale 1ns/1ps
`default_nettype none
module vp_top (
	input wire logic aclk, // 250 MHz clock
	input wire logic aresetn, // synchronous reset, active low
	input wire logic ce, // clock enable, freezes state when low
	input wire logic [7:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [7:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic [2:0][15:0] v_fund, // fundamental per channel
	input wire logic [2:0][15:0] v_rms, // true rms per channel
	input wire logic [2:0][15:0] v_avg, // sliding average per channel
	input wire logic [2:0][15:0] i_neutral, // neutral side currents
	input wire logic external_block_source, // assigned block signal
	input wire logic potential_loss_supervision, // supervision block
	input wire logic transformer_supervision, // supervision block
	output logic [2:0] phase_alarm, // per-phase alarm flags
	output logic [2:0] phase_trip, // per-phase trip flags
	output logic irq // level interrupt
);
	// ==========================================
	// helpers
	// scales a by b/1024
	function automatic logic [15:0] scale(input logic [15:0] a, input logic [15:0] b);
		logic [31:0] p;
		p = 32'(a) * 32'(b);
		return p[25:10];
	endfunction
	// byte-lane merge for writes
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int k = 0; k < 4; k++) begin
			if (s[k]) r[k*8 +: 8] = d[k*8 +: 8];
		end
		return r;
	endfunction
	// ==========================================
	// local copies of package widths, declared ahead of their first use
	localparam int CTRL_W = vp_pkg::CTRL_W;
	localparam int ST_W = vp_pkg::ST_W;
	// ==========================================
	// register state
	logic awr_reg, awr_next, wr_reg, wr_next, bv_reg, bv_next; // write channel
	logic [7:0] awa_reg, awa_next; // latched write address
	logic [31:0] wd_reg, wd_next; // latched write data
	logic [3:0] ws_reg, ws_next; // latched strobes
	logic aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next; // halves held
	logic [1:0] br_reg, br_next, rr_reg, rr_next; // responses
	logic arr_reg, arr_next, rv_reg, rv_next; // read channel
	logic [31:0] rd_reg, rd_next; // read data
	logic [CTRL_W-1:0] ctrl_reg, ctrl_next; // control
	logic [15:0] pick_reg, pick_next, drop_reg, drop_next; // thresholds
	logic [31:0] tdl_reg, tdl_next, idl_reg, idl_next; // delays
	logic [15:0] ithr_reg, ithr_next, rate_reg, rate_next; // current, rating
	logic [ST_W-1:0] st_reg, st_next, msk_reg, msk_next; // irq bits
	logic irq_reg, irq_next; // interrupt flop
	// ==========================================
	// protection state
	logic [2:0] pp_reg, pp_next; // per-phase picked
	logic [2:0] al_reg, al_next, tr_reg, tr_next; // flags
	logic [31:0] tmr_reg, tmr_next; // trip timer
	logic iblk_reg, iblk_next; // minimum current block
	logic [31:0] icnt_reg, icnt_next; // re-enable counter
	logic under, conn_pp, meas_pp, all_low, inhibit, elem_pu, low_set;
	logic [15:0] nominal, thr, dthr; // nominal and thresholds
	logic [2:0][15:0] vsel; // selected voltages
	logic [1:0] cnt3, need; // phases picked, phases needed
	logic [ST_W-1:0] ev; // events this cycle
	// ==========================================
	// protection combinational
	always_comb begin
		under = ctrl_reg[vp_pkg::CB_UNDER];
		conn_pp = ctrl_reg[vp_pkg::CB_CONN_PP];
		meas_pp = conn_pp | ctrl_reg[vp_pkg::CB_MEAS_PP];
		nominal = meas_pp ? rate_reg : scale(rate_reg, vp_pkg::INV_SQRT3);
		thr = scale(nominal, pick_reg);
		dthr = scale(thr, drop_reg);
		low_set = under && (pick_reg < vp_pkg::FLOOR_PU);
		// channel i is phase i or line i(i+1) by wiring
		for (int i = 0; i < 3; i++) begin
			case (ctrl_reg[vp_pkg::CB_METH +: 2])
				vp_pkg::METH_FUND: vsel[i] = v_fund[i];
				vp_pkg::METH_RMS: vsel[i] = v_rms[i];
				vp_pkg::METH_AVG: vsel[i] = v_avg[i];
				default: vsel[i] = v_fund[i];
			endcase
		end
		cnt3 = 2'd0;
		for (int i = 0; i < 3; i++) begin
			// pickup with dropout hysteresis
			if (under) begin
				pp_next[i] = pp_reg[i] ? !(vsel[i] > dthr) : (vsel[i] < thr);
			end else begin
				pp_next[i] = pp_reg[i] ? !(vsel[i] < dthr) : (vsel[i] > thr);
			end
			cnt3 = cnt3 + 2'(pp_reg[i]);
		end
		need = (ctrl_reg[vp_pkg::CB_NEED +: 2] == 2'd0) ? 2'd1 : ctrl_reg[vp_pkg::CB_NEED +: 2];
		// minimum current check on neutral inputs
		all_low = (i_neutral[0] < ithr_reg) && (i_neutral[1] < ithr_reg)
			&& (i_neutral[2] < ithr_reg);
		iblk_next = iblk_reg;
		icnt_next = 32'd0;
		if (!(under && ctrl_reg[vp_pkg::CB_IMIN_EN])) begin
			iblk_next = 1'b0;
		end else if (all_low) begin
			iblk_next = 1'b1;
		end else if (iblk_reg) begin
			// hold block until delay expires
			if (icnt_reg >= idl_reg) iblk_next = 1'b0;
			else icnt_next = icnt_reg + 32'd1;
		end
		inhibit = (ctrl_reg[vp_pkg::CB_EXT_ACT] && external_block_source)
			|| (under && iblk_reg)
			|| (under && ctrl_reg[vp_pkg::CB_SUPV_EN]
			&& (potential_loss_supervision || transformer_supervision));
		elem_pu = (cnt3 >= need) && !inhibit;
		// trip timer runs while pickup persists
		tmr_next = !elem_pu ? 32'd0 : (tmr_reg < tdl_reg) ? tmr_reg + 32'd1 : tmr_reg;
		al_next = elem_pu ? pp_reg : 3'd0;
		tr_next = (elem_pu && tmr_reg >= tdl_reg) ? pp_reg : 3'd0;
		ev = '0;
		ev[vp_pkg::SB_ALARM] = (|al_next) && !(|al_reg);
		ev[vp_pkg::SB_TRIP] = (|tr_next) && !(|tr_reg);
		ev[vp_pkg::SB_IMIN] = iblk_next && !iblk_reg;
		ev[vp_pkg::SB_LOWSET] = low_set;
	end
	// ==========================================
	// bus combinational
	always_comb begin
		awr_next = awr_reg;
		wr_next = wr_reg;
		bv_next = bv_reg;
		br_next = br_reg;
		awa_next = awa_reg;
		wd_next = wd_reg;
		ws_next = ws_reg;
		aw_hold_next = aw_hold_reg;
		w_hold_next = w_hold_reg;
		arr_next = arr_reg;
		rv_next = rv_reg;
		rr_next = rr_reg;
		rd_next = rd_reg;
		ctrl_next = ctrl_reg;
		pick_next = pick_reg;
		drop_next = drop_reg;
		tdl_next = tdl_reg;
		idl_next = idl_reg;
		ithr_next = ithr_reg;
		rate_next = rate_reg;
		msk_next = msk_reg;
		st_next = st_reg;
		// capture address and data in either order
		if (s_axi_awvalid && awr_reg) begin
			awa_next = s_axi_awaddr;
			aw_hold_next = 1'b1;
			awr_next = 1'b0;
		end
		if (s_axi_wvalid && wr_reg) begin
			wd_next = s_axi_wdata;
			ws_next = s_axi_wstrb;
			w_hold_next = 1'b1;
			wr_next = 1'b0;
		end
		// perform write once both halves are held
		if (aw_hold_reg && w_hold_reg && !bv_reg) begin
			bv_next = 1'b1;
			br_next = vp_pkg::RESP_OK;
			aw_hold_next = 1'b0;
			w_hold_next = 1'b0;
			case (awa_reg)
				vp_pkg::OFS_CTRL: ctrl_next = CTRL_W'(merge(32'(ctrl_reg), wd_reg, ws_reg));
				vp_pkg::OFS_PICKUP: pick_next = 16'(merge(32'(pick_reg), wd_reg, ws_reg));
				vp_pkg::OFS_DROPOUT: drop_next = 16'(merge(32'(drop_reg), wd_reg, ws_reg));
				vp_pkg::OFS_TDELAY: tdl_next = merge(tdl_reg, wd_reg, ws_reg);
				vp_pkg::OFS_IMIN_THR: ithr_next = 16'(merge(32'(ithr_reg), wd_reg, ws_reg));
				vp_pkg::OFS_IMIN_DLY: idl_next = merge(idl_reg, wd_reg, ws_reg);
				vp_pkg::OFS_RATING: rate_next = 16'(merge(32'(rate_reg), wd_reg, ws_reg));
				vp_pkg::OFS_STATUS: st_next = st_reg & ~(ST_W'(wd_reg) & {ST_W{ws_reg[0]}});
				vp_pkg::OFS_MASK: msk_next = ST_W'(merge(32'(msk_reg), wd_reg, ws_reg));
				vp_pkg::OFS_STATE: br_next = vp_pkg::RESP_ERR;
				default: br_next = vp_pkg::RESP_ERR;
			endcase
		end
		if (bv_reg && s_axi_bready) begin
			bv_next = 1'b0;
			awr_next = 1'b1;
			wr_next = 1'b1;
		end
		// read: one at a time
		if (s_axi_arvalid && arr_reg) begin
			arr_next = 1'b0;
			rv_next = 1'b1;
			rr_next = vp_pkg::RESP_OK;
			case (s_axi_araddr)
				vp_pkg::OFS_CTRL: rd_next = 32'(ctrl_reg);
				vp_pkg::OFS_PICKUP: rd_next = 32'(pick_reg);
				vp_pkg::OFS_DROPOUT: rd_next = 32'(drop_reg);
				vp_pkg::OFS_TDELAY: rd_next = tdl_reg;
				vp_pkg::OFS_IMIN_THR: rd_next = 32'(ithr_reg);
				vp_pkg::OFS_IMIN_DLY: rd_next = idl_reg;
				vp_pkg::OFS_RATING: rd_next = 32'(rate_reg);
				vp_pkg::OFS_STATUS: rd_next = 32'(st_reg);
				vp_pkg::OFS_MASK: rd_next = 32'(msk_reg);
				// nominal in the upper half, flags below, bits 15:13 and 5:3 read zero
				vp_pkg::OFS_STATE: rd_next = {nominal, 3'd0, iblk_reg, tr_reg, al_reg, 3'd0, pp_reg};
				default: begin
					rd_next = 32'h0000_0000;
					rr_next = vp_pkg::RESP_ERR;
				end
			endcase
		end
		if (rv_reg && s_axi_rready) begin
			rv_next = 1'b0;
			arr_next = 1'b1;
		end
		// sticky events, set wins over clear
		st_next = st_next | ev;
		irq_next = |(st_reg & msk_reg);
	end
	// ==========================================
	// registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{awr_reg, wr_reg, arr_reg} <= 3'b111;
			{bv_reg, rv_reg, aw_hold_reg, w_hold_reg, irq_reg, iblk_reg} <= 6'd0;
			{br_reg, rr_reg} <= 4'd0;
			awa_reg <= 8'h00;
			wd_reg <= 32'h0000_0000;
			ws_reg <= 4'h0;
			rd_reg <= 32'h0000_0000;
			ctrl_reg <= '0;
			pick_reg <= vp_pkg::RST_PICKUP;
			drop_reg <= vp_pkg::RST_DROPOUT;
			tdl_reg <= vp_pkg::RST_TDELAY;
			idl_reg <= vp_pkg::RST_TDELAY;
			ithr_reg <= 16'h0000;
			rate_reg <= vp_pkg::RST_RATING;
			st_reg <= '0;
			msk_reg <= '0;
			{pp_reg, al_reg, tr_reg} <= 9'd0;
			tmr_reg <= 32'h0000_0000;
			icnt_reg <= 32'h0000_0000;
		end else if (ce) begin
			{awr_reg, wr_reg, arr_reg} <= {awr_next, wr_next, arr_next};
			{bv_reg, rv_reg, aw_hold_reg, w_hold_reg} <= {bv_next, rv_next, aw_hold_next, w_hold_next};
			{irq_reg, iblk_reg} <= {irq_next, iblk_next};
			{br_reg, rr_reg} <= {br_next, rr_next};
			awa_reg <= awa_next;
			wd_reg <= wd_next;
			ws_reg <= ws_next;
			rd_reg <= rd_next;
			ctrl_reg <= ctrl_next;
			pick_reg <= pick_next;
			drop_reg <= drop_next;
			tdl_reg <= tdl_next;
			idl_reg <= idl_next;
			ithr_reg <= ithr_next;
			rate_reg <= rate_next;
			st_reg <= st_next;
			msk_reg <= msk_next;
			{pp_reg, al_reg, tr_reg} <= {pp_next, al_next, tr_next};
			tmr_reg <= tmr_next;
			icnt_reg <= icnt_next;
		end
	end
	// outputs straight from flops
	assign {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp} = {awr_reg, wr_reg, bv_reg, br_reg};
	assign {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp} = {arr_reg, rv_reg, rd_reg, rr_reg};
	assign {phase_alarm, phase_trip, irq} = {al_reg, tr_reg, irq_reg};
	// ==========================================
	// assertions
	sequence seq_all_low;
		ce && under && ctrl_reg[vp_pkg::CB_IMIN_EN] && all_low;
	endsequence
	sequence seq_trip_rise;
		ce && (|tr_next) && !(|tr_reg);
	endsequence
	AST_TRIP_AFTER_DELAY: assert property (@(posedge aclk) disable iff (!aresetn)
		seq_trip_rise |-> (tmr_reg >= tdl_reg) && elem_pu) else $error("trip before delay");
	AST_TRIP_UNDER_ALARM: assert property (@(posedge aclk) disable iff (!aresetn)
		(tr_reg & ~al_reg) == 3'd0) else $error("trip without alarm");
	AST_IMIN_BLOCK: assert property (@(posedge aclk) disable iff (!aresetn)
		seq_all_low |=> iblk_reg) else $error("minimum current did not block");
	AST_IMIN_UNDER_ONLY: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && !under |=> !iblk_reg) else $error("current block in overvoltage mode");
	AST_IMIN_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && iblk_reg && !all_low && icnt_reg < idl_reg && under
		&& ctrl_reg[vp_pkg::CB_IMIN_EN] |=> iblk_reg) else $error("early re-enable");
	AST_EXT_BLOCK: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && ctrl_reg[vp_pkg::CB_EXT_ACT] && external_block_source |=> al_reg == 3'd0)
		else $error("alarm while externally blocked");
	AST_NOMINAL_PP: assert property (@(posedge aclk) disable iff (!aresetn)
		conn_pp |-> nominal == rate_reg) else $error("nominal not rating");
	AST_IRQ: assert property (@(posedge aclk) disable iff (!aresetn)
		ce ##1 ce |-> irq_reg == |($past(st_reg) & $past(msk_reg))) else $error("irq mismatch");
	AST_WRITE_RESP: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && aw_hold_reg && w_hold_reg && !bv_reg |=> bv_reg) else $error("no write response");
endmodule
`default_nettype wire

// >>> core/vp_pkg.sv
// constants shared by the voltage protection element
package vp_pkg;
	// ==========================================
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00; // control bits
	localparam logic [7:0] OFS_PICKUP = 8'h04; // pickup, 1/1024 of nominal
	localparam logic [7:0] OFS_DROPOUT = 8'h08; // dropout ratio, 1/1024
	localparam logic [7:0] OFS_TDELAY = 8'h0C; // trip delay, cycles
	localparam logic [7:0] OFS_IMIN_THR = 8'h10; // minimum current threshold
	localparam logic [7:0] OFS_IMIN_DLY = 8'h14; // re-enable delay, cycles
	localparam logic [7:0] OFS_RATING = 8'h18; // transformer secondary rating
	localparam logic [7:0] OFS_STATUS = 8'h1C; // sticky events, write one to clear
	localparam logic [7:0] OFS_MASK = 8'h20; // interrupt mask
	localparam logic [7:0] OFS_STATE = 8'h24; // live state, read only
	// ==========================================
	// control field positions
	localparam int CB_UNDER = 0; // 1 undervoltage, 0 overvoltage
	localparam int CB_METH = 1; // two bits, measuring method
	localparam int CB_MEAS_PP = 3; // measuring mode phase to phase
	localparam int CB_CONN_PP = 4; // transformer_connection phase to phase
	localparam int CB_NEED = 5; // two bits, phases needed 1..3
	localparam int CB_IMIN_EN = 7; // minimum current check enable
	localparam int CB_EXT_ACT = 8; // external_block_activation
	localparam int CB_SUPV_EN = 9; // measuring circuit supervision
	localparam int CTRL_W = 10; // control width
	// ==========================================
	// measuring methods
	localparam logic [1:0] METH_FUND = 2'h0; // fundamental
	localparam logic [1:0] METH_RMS = 2'h1; // true rms
	localparam logic [1:0] METH_AVG = 2'h2; // sliding average
	localparam int AVG_WINDOW_MIN = 10; // upstream average window, minutes
	// ==========================================
	// status bits
	localparam int SB_ALARM = 0; // alarm rose
	localparam int SB_TRIP = 1; // trip rose
	localparam int SB_IMIN = 2; // minimum current block rose
	localparam int SB_LOWSET = 3; // pickup below supervision floor
	localparam int ST_W = 4; // status width
	// ==========================================
	// scaling and reset values
	localparam logic [15:0] INV_SQRT3 = 16'h0250; // 1/sqrt3 in 1/1024
	localparam logic [15:0] FLOOR_PU = 16'h001F; // 0.03 of nominal in 1/1024
	localparam logic [15:0] RST_PICKUP = 16'h0400; // nominal
	localparam logic [15:0] RST_DROPOUT = 16'h03E1; // about 0.97
	localparam logic [15:0] RST_RATING = 16'h0064; // plain default rating
	localparam logic [31:0] RST_TDELAY = 32'h0000_0010; // trip delay cycles
	localparam logic [1:0] RESP_OK = 2'h0; // okay
	localparam logic [1:0] RESP_ERR = 2'h2; // slave error
endpackage

// >>> verification/vp_front_end.sv
// measurement front end model that feeds levels and currents to the element
`timescale 1ns/1ps
`default_nettype none
module vp_front_end (
	input wire logic aclk, // sample clock
	input wire logic [1:0] src, // method that carries the level
	input wire logic [2:0][15:0] lvl, // per-phase level on that method
	input wire logic [15:0] idle, // level shown on the other methods
	input wire logic [2:0][15:0] cur, // per-phase neutral side current
	output logic [2:0][15:0] v_fund, // fundamental per channel
	output logic [2:0][15:0] v_rms, // true rms per channel
	output logic [2:0][15:0] v_avg, // sliding average per channel
	output logic [2:0][15:0] i_neutral // neutral side currents
);
	// ==========================================
	// one cycle of measurement latency, methods differ so a wrong pick shows
	always_ff @(posedge aclk) begin
		for (int k = 0; k < 3; k++) begin
			v_fund[k] <= (src == vp_pkg::METH_FUND) ? lvl[k] : idle;
			v_rms[k] <= (src == vp_pkg::METH_RMS) ? lvl[k] : idle;
			v_avg[k] <= (src == vp_pkg::METH_AVG) ? lvl[k] : idle; // window done upstream, level passed through as given
			i_neutral[k] <= cur[k]; // only neutral side set exists
		end
	end
endmodule
`default_nettype wire

// >>> verification/voltage_protection_element_tb.sv
// testbench for the voltage protection element
`timescale 1ns/1ps
`default_nettype none
module voltage_protection_element_tb;
	// ==========================================
	// signals
	logic aclk, aresetn, ce; // clock, reset, enable
	logic [7:0] s_axi_awaddr, s_axi_araddr; // bus addresses
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready; // write handshakes
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready; // response and read
	logic s_axi_rvalid, s_axi_rready; // read data handshake
	logic [31:0] s_axi_wdata, s_axi_rdata, rdat; // bus data
	logic [3:0] s_axi_wstrb; // write strobes
	logic [1:0] s_axi_bresp, s_axi_rresp, resp, src; // responses, method select
	logic [2:0][15:0] lvl, cur, v_fund, v_rms, v_avg, i_neutral; // analog levels
	logic [15:0] idle; // level on unselected methods
	logic ext_src, pl_sup, tr_sup, irq; // block inputs, interrupt
	logic [2:0] phase_alarm, phase_trip; // flags
	int num_errors = 0;
	int checks_done = 0;
	int cyc = 0;
	localparam logic [15:0] HI = 16'h00C8; // well above nominal
	localparam logic [15:0] LO = 16'h000A; // well below nominal
	localparam logic [1:0] FU = vp_pkg::METH_FUND; // fundamental
	// ==========================================
	// design and partner
	vp_top i_vp_top (.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .v_fund(v_fund), .v_rms(v_rms),
		.v_avg(v_avg), .i_neutral(i_neutral), .external_block_source(ext_src),
		.potential_loss_supervision(pl_sup), .transformer_supervision(tr_sup),
		.phase_alarm(phase_alarm), .phase_trip(phase_trip), .irq(irq));
	vp_front_end i_vp_front_end (.aclk(aclk), .src(src), .lvl(lvl), .idle(idle), .cur(cur),
		.v_fund(v_fund), .v_rms(v_rms), .v_avg(v_avg), .i_neutral(i_neutral));
	// ==========================================
	// clock and timeout
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			end_of_test();
		end
	end
	// ==========================================
	// tasks
	task automatic end_of_test();
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic ca(input string what, input logic [2:0] e); // alarm flags compare
		chk(what, {29'h0, phase_alarm}, {29'h0, e});
	endtask
	// write: address and data offered together, bready held high
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (!aw && s_axi_awready) begin
				aw = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w && s_axi_wready) begin
				w = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end while (!(aw && w && s_axi_bvalid));
		resp = s_axi_bresp;
	endtask
	// read: rready held high, data taken at the rvalid edge
	task automatic rd(input logic [7:0] a);
		logic t;
		t = 1'b0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (!t && s_axi_arready) begin
				t = 1'b1;
				s_axi_arvalid <= 1'b0;
			end
		end while (!(t && s_axi_rvalid));
		rdat = s_axi_rdata;
		resp = s_axi_rresp;
	endtask
	// control word from its fields
	function automatic logic [31:0] cw(input logic u, input logic [1:0] m, input logic mp,
		input logic cp, input logic [1:0] nd, input logic [2:0] x);
		cw = '0;
		cw[vp_pkg::CB_UNDER] = u;
		cw[vp_pkg::CB_METH +: 2] = m;
		cw[vp_pkg::CB_MEAS_PP] = mp;
		cw[vp_pkg::CB_CONN_PP] = cp;
		cw[vp_pkg::CB_NEED +: 2] = nd;
		cw[vp_pkg::CB_IMIN_EN] = x[0];
		cw[vp_pkg::CB_EXT_ACT] = x[1];
		cw[vp_pkg::CB_SUPV_EN] = x[2];
	endfunction
	// phases in on get the faulted level, the rest stay healthy
	task automatic ap(input logic [1:0] s, input logic [2:0] on, input logic u);
		src <= s;
		idle <= u ? HI : LO;
		for (int k = 0; k < 3; k++) begin
			lvl[k] <= (on[k] ^ u) ? HI : LO;
		end
		repeat (6) @(posedge aclk);
	endtask
	// ==========================================
	// main sequence
	initial begin
		aresetn = 1'b0;
		ce = 1'b1;
		s_axi_awvalid = 1'b0;
		s_axi_wvalid = 1'b0;
		s_axi_arvalid = 1'b0;
		s_axi_bready = 1'b1;
		s_axi_rready = 1'b1;
		s_axi_wstrb = 4'hF;
		s_axi_awaddr = '0;
		s_axi_araddr = '0;
		s_axi_wdata = '0;
		{ext_src, pl_sup, tr_sup} = 3'b000;
		src = FU;
		lvl = '0;
		idle = '0;
		cur = '0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(vp_pkg::OFS_PICKUP);
		chk("pickup reset", rdat, {16'h0, vp_pkg::RST_PICKUP});
		rd(8'h28);
		chk("unmapped resp", {30'h0, resp}, {30'h0, vp_pkg::RESP_ERR});
		wr(vp_pkg::OFS_STATE, 32'h0000_0001);
		chk("state write resp", {30'h0, resp}, {30'h0, vp_pkg::RESP_ERR});
		// nominal reference per connection and measuring mode
		rd(vp_pkg::OFS_STATE);
		chk("nominal pg", rdat[31:16], (vp_pkg::RST_RATING * vp_pkg::INV_SQRT3) >> 10);
		wr(vp_pkg::OFS_CTRL, cw(0, FU, 1, 0, 1, 0));
		rd(vp_pkg::OFS_STATE);
		chk("nominal meas pp", rdat[31:16], vp_pkg::RST_RATING);
		wr(vp_pkg::OFS_CTRL, cw(0, FU, 0, 1, 1, 0));
		rd(vp_pkg::OFS_STATE);
		chk("nominal conn pp", rdat[31:16], vp_pkg::RST_RATING);
		wr(vp_pkg::OFS_TDELAY, 32'h0000_0008); // short delay, longer than supervision
		// single phase pickup, trip after delay, clear on dropout
		for (int c = 0; c < 2; c++) begin
			wr(vp_pkg::OFS_CTRL, cw(0, FU, 1, c[0], 1, 0));
			ap(FU, 3'b010, 0);
			ca("alarm one phase", 3'b010);
			chk("trip early", {29'h0, phase_trip}, 32'h0000_0000);
			repeat (10) @(posedge aclk);
			chk("trip", {29'h0, phase_trip}, 32'h0000_0002);
			ap(FU, 3'b000, 0);
			ca("alarm dropout", 3'b000);
		end
		// phases needed one, two, three
		for (int n = 1; n < 4; n++) begin
			wr(vp_pkg::OFS_CTRL, cw(0, FU, 1, 0, n[1:0], 0));
			ap(FU, 3'b011, 0);
			ca("phases needed", (n < 3) ? 3'b011 : 3'b000);
		end
		ap(FU, 3'b111, 0);
		ca("all phases", 3'b111);
		// each measuring method reacts to its own source only
		for (int m = 0; m < 3; m++) begin
			wr(vp_pkg::OFS_CTRL, cw(0, m[1:0], 1, 0, 1, 0));
			ap(2'((m + 1) % 3), 3'b111, 0);
			ca("other method", 3'b000);
			ap(m[1:0], 3'b111, 0);
			ca("own method", 3'b111);
		end
		// undervoltage and minimum current check
		wr(vp_pkg::OFS_IMIN_THR, 32'h0000_0032);
		wr(vp_pkg::OFS_IMIN_DLY, 32'h0000_0014);
		wr(vp_pkg::OFS_CTRL, cw(1, FU, 1, 0, 1, 0));
		ap(FU, 3'b111, 1);
		ca("under no check", 3'b111);
		wr(vp_pkg::OFS_CTRL, cw(1, FU, 1, 0, 1, 3'b001));
		repeat (6) @(posedge aclk);
		ca("dead currents", 3'b000);
		cur[0] <= 16'h0064;
		repeat (20) @(posedge aclk);
		ca("re-enable wait", 3'b000);
		repeat (10) @(posedge aclk);
		ca("re-enabled", 3'b111);
		cur[0] <= 16'h0000;
		repeat (6) @(posedge aclk);
		ca("blocked again", 3'b000);
		wr(vp_pkg::OFS_CTRL, cw(0, FU, 1, 0, 1, 3'b001));
		ap(FU, 3'b111, 0);
		ca("over ignores current", 3'b111);
		// clock enable low freezes the flags, release lets them follow
		ce <= 1'b0;
		ap(FU, 3'b000, 0);
		ca("frozen", 3'b111);
		ce <= 1'b1;
		repeat (6) @(posedge aclk);
		ca("thawed", 3'b000);
		ap(FU, 3'b111, 0);
		// external block with and without activation
		ext_src <= 1'b1;
		wr(vp_pkg::OFS_CTRL, cw(0, FU, 1, 0, 1, 3'b010));
		repeat (6) @(posedge aclk);
		ca("ext block", 3'b000);
		wr(vp_pkg::OFS_CTRL, cw(0, FU, 1, 0, 1, 3'b000));
		repeat (6) @(posedge aclk);
		ca("ext inactive", 3'b111);
		ext_src <= 1'b0;
		// supervision blocks undervoltage on fuse failure
		wr(vp_pkg::OFS_CTRL, cw(1, FU, 1, 0, 1, 3'b100));
		tr_sup <= 1'b1;
		ap(FU, 3'b111, 1);
		ca("transformer supv", 3'b000);
		tr_sup <= 1'b0;
		pl_sup <= 1'b1;
		repeat (6) @(posedge aclk);
		ca("potential supv", 3'b000);
		pl_sup <= 1'b0;
		// interrupt: raise, mask, clear
		ap(FU, 3'b000, 1);
		wr(vp_pkg::OFS_STATUS, 32'h0000_000F);
		ap(FU, 3'b111, 1);
		rd(vp_pkg::OFS_STATUS);
		chk("status alarm", {31'h0, rdat[vp_pkg::SB_ALARM]}, 32'h0000_0001);
		chk("irq masked", {31'h0, irq}, 32'h0000_0000);
		wr(vp_pkg::OFS_MASK, 32'h0000_0001);
		repeat (2) @(posedge aclk);
		chk("irq raised", {31'h0, irq}, 32'h0000_0001);
		wr(vp_pkg::OFS_STATUS, 32'h0000_0001);
		repeat (2) @(posedge aclk);
		chk("irq cleared", {31'h0, irq}, 32'h0000_0000);
		// pickup under the supervision floor is flagged
		wr(vp_pkg::OFS_PICKUP, 32'h0000_0010);
		repeat (3) @(posedge aclk);
		rd(vp_pkg::OFS_STATUS);
		chk("low pickup", {31'h0, rdat[vp_pkg::SB_LOWSET]}, 32'h0000_0001);
		end_of_test();
	end
endmodule
`default_nettype wire
